// ===== design/fnd_config.sv
// Serial configuration capture and fractional-N divide setting calculation
module fnd_config
#(
  parameter int unsigned LOCK_FILT = fnd_pkg::LOCK_FILT_CYC
) (
  // Core clock and reset
  input  wire logic              core_clk,
  input  wire logic              rst,
  // Serial programming link
  input  wire logic              serClk,
  input  wire logic              serData,
  input  wire logic              latchStrobe,
  // Lock indication from the loop
  input  wire logic              lockRaw,
  output logic                   lockPin,
  // Divide setting
  output logic [7:0]             divInteger,
  output logic [9:0]             fracNumerator,
  output logic [9:0]             fracDenominator,
  output logic [1:0]             refDivide,
  output logic [1:0]             refFreqCode,
  // Mode and oscillator control
  output logic                   txMode,
  output logic                   bandSelect,
  output logic                   upperOscEn,
  output logic                   lowerOscEn,
  output logic [1:0]             outLevelSel,
  output logic                   builtinWordsSel,
  // Effective fixed configuration contents
  output logic [15:0]            cfgOneFixed,
  output fnd_pkg::fnd_word_t     cfgTwoWord,
  output fnd_pkg::fnd_word_t     cfgThreeWord,
  output fnd_pkg::fnd_word_t     cfgFourWord,
  output fnd_pkg::fnd_word_t     cfgFiveWord,
  // One-cycle pulse for every word accepted
  output logic                   wordLoaded
);
  timeunit 1ns;
  timeprecision 100ps;
  import fnd_pkg::*;

  if (LOCK_FILT < 2 || LOCK_FILT > 65535) begin : gFiltRange
    $error("LOCK_FILT out of range");
  end

  // Link domain
  fnd_word_t shiftReg_q;

  always_ff @(posedge serClk) begin
    shiftReg_q <= {shiftReg_q[WORD_W-2:0], serData};
  end

  // Crossing: word is static while strobe high, taken after strobe sync
  fnd_word_t wordMeta_q;
  fnd_word_t wordSync_q;
  logic      strobeMeta_q, strobeSync_q, strobeDly_q, strobeDly2_q;

  always_ff @(posedge core_clk) begin
    wordMeta_q <= shiftReg_q;
    wordSync_q <= wordMeta_q;
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      strobeMeta_q <= 1'b0;
      strobeSync_q <= 1'b0;
      strobeDly_q  <= 1'b0;
      strobeDly2_q <= 1'b0;
    end else begin
      strobeMeta_q <= latchStrobe;
      strobeSync_q <= strobeMeta_q;
      strobeDly_q  <= strobeSync_q;
      strobeDly2_q <= strobeDly_q;
    end
  end

  logic loadEv;
  assign loadEv = strobeDly_q & ~strobeDly2_q;

  // First configuration word fields
  logic        builtinSel_q;
  logic        lockEn_q;
  logic [1:0]  level_q;
  logic [1:0]  refCode_q;
  logic [15:0] fixedOne_q;

  // Address decode
  logic hitFreq, hitOne, hitTwo, hitW3, hitW4, hitW5;

  always_comb begin
    hitFreq = loadEv && (wordSync_q[1:0] == ADDR_FREQ);
    hitOne  = loadEv && (wordSync_q[1:0] == ADDR_ONE);
    hitTwo  = loadEv && (wordSync_q[1:0] == ADDR_TWO);
    hitW3   = loadEv && !builtinSel_q && (wordSync_q[2:0] == ADDR_W3);
    hitW4   = loadEv && !builtinSel_q && (wordSync_q[3:0] == ADDR_W4);
    hitW5   = loadEv && !builtinSel_q && (wordSync_q[4:0] == ADDR_W5);
  end

  // Frequency word
  logic       dir_q;
  logic       band_q;
  logic [3:0] mainCount_q;
  logic [2:0] swallowCount_q;
  logic [9:0] fracNum_q;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      dir_q          <= 1'b0;
      band_q         <= 1'b0;
      mainCount_q    <= MAIN_RST;
      swallowCount_q <= 3'h0;
      fracNum_q      <= 10'h000;
    end else if (hitFreq) begin
      dir_q          <= wordSync_q[FW_DIR_BIT];
      band_q         <= wordSync_q[FW_BAND_BIT];
      mainCount_q    <= wordSync_q[FW_MAIN_HI:FW_MAIN_LO];
      swallowCount_q <= wordSync_q[FW_SWAL_HI:FW_SWAL_LO];
      fracNum_q      <= wordSync_q[FW_FRAC_HI:FW_FRAC_LO];
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      builtinSel_q <= 1'b1;
      lockEn_q     <= 1'b0;
      level_q      <= LEVEL_RST;
      refCode_q    <= REF_CODE_RST;
      fixedOne_q   <= C1_FIXED_DEF;
    end else if (hitOne) begin
      builtinSel_q <= wordSync_q[C1_BUILTIN_BIT];
      lockEn_q     <= wordSync_q[C1_LOCK_BIT];
      level_q      <= wordSync_q[C1_LEVEL_HI:C1_LEVEL_LO];
      refCode_q    <= wordSync_q[C1_REF_HI:C1_REF_LO];
      fixedOne_q   <= wordSync_q[C1_FIXED_HI:C1_FIXED_LO];
    end
  end

  // Fixed words two to five
  fnd_word_t wordTwo_q;
  fnd_word_t wordThree_q;
  fnd_word_t wordFour_q;
  fnd_word_t wordFive_q;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      wordTwo_q   <= C2_DEF;
      wordThree_q <= W3_DEF;
      wordFour_q  <= W4_DEF;
      wordFive_q  <= W5_DEF;
    end else begin
      if (hitTwo) begin
        wordTwo_q <= wordSync_q;
      end
      if (hitW3) begin
        wordThree_q <= wordSync_q;
      end
      if (hitW4) begin
        wordFour_q <= wordSync_q;
      end
      if (hitW5) begin
        wordFive_q <= wordSync_q;
      end
    end
  end

  // Divide setting
  logic [7:0] mult_d;
  logic [7:0] divInt_d;
  logic [1:0] refDiv_d;
  logic [9:0] den_d;

  always_comb begin
    mult_d   = band_q ? MULT_UPPER : MULT_LOWER;
    divInt_d = 8'(mult_d * {4'h0, mainCount_q}) + {5'h00, swallowCount_q};
    // codes 10 and 11 are the doubled references
    refDiv_d = refCode_q[1] ? REF_DIV_TWO : REF_DIV_ONE;
    if (!dir_q) begin
      unique case (refCode_q)
        2'h0: den_d = DEN_RX_00;
        2'h1: den_d = DEN_RX_01;
        2'h2: den_d = DEN_RX_10;
        2'h3: den_d = DEN_RX_11;
      endcase
    end else if (!band_q) begin
      unique case (refCode_q)
        2'h0: den_d = DEN_TL_00;
        2'h1: den_d = DEN_TL_01;
        2'h2: den_d = DEN_TL_10;
        2'h3: den_d = DEN_TL_11;
      endcase
    end else begin
      unique case (refCode_q)
        2'h0: den_d = DEN_TU_00;
        2'h1: den_d = DEN_TU_01;
        2'h2: den_d = DEN_TU_10;
        2'h3: den_d = DEN_TU_11;
      endcase
    end
  end

  logic [7:0] divInt_q;
  logic [9:0] fracOut_q;
  logic [9:0] den_q;
  logic [1:0] refDiv_q;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      divInt_q  <= 8'h00;
      fracOut_q <= 10'h000;
      den_q     <= DEN_RX_00;
      refDiv_q  <= REF_DIV_ONE;
    end else begin
      divInt_q  <= divInt_d;
      fracOut_q <= fracNum_q;
      den_q     <= den_d;
      refDiv_q  <= refDiv_d;
    end
  end

  // Mode outputs
  logic       tx_q, bandOut_q, upperEn_q, lowerEn_q, builtinOut_q, loaded_q;
  logic [1:0] levelOut_q, refOut_q;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      tx_q         <= 1'b0;
      bandOut_q    <= 1'b0;
      upperEn_q    <= 1'b0;
      lowerEn_q    <= 1'b1;
      levelOut_q   <= LEVEL_RST;
      refOut_q     <= REF_CODE_RST;
      builtinOut_q <= 1'b1;
      loaded_q     <= 1'b0;
    end else begin
      tx_q         <= dir_q;
      bandOut_q    <= band_q;
      upperEn_q    <= band_q;
      lowerEn_q    <= ~band_q;
      levelOut_q   <= level_q;
      refOut_q     <= refCode_q;
      builtinOut_q <= builtinSel_q;
      loaded_q     <= hitFreq | hitOne | hitTwo | hitW3 | hitW4 | hitW5;
    end
  end

  // Effective fixed contents
  logic [15:0] fixedOneOut_q;
  fnd_word_t   twoOut_q;
  fnd_word_t   threeOut_q;
  fnd_word_t   fourOut_q;
  fnd_word_t   fiveOut_q;

  always_ff @(posedge core_clk) begin
    if (rst || builtinSel_q) begin
      fixedOneOut_q <= C1_FIXED_DEF;
      twoOut_q      <= C2_DEF;
      threeOut_q    <= W3_DEF;
      fourOut_q     <= W4_DEF;
      fiveOut_q     <= W5_DEF;
    end else begin
      fixedOneOut_q <= fixedOne_q;
      twoOut_q      <= wordTwo_q;
      threeOut_q    <= wordThree_q;
      fourOut_q     <= wordFour_q;
      fiveOut_q     <= wordFive_q;
    end
  end

  // Lock indication
  logic        lockMeta_q;
  logic        lockSync_q;
  logic        lockPrev_q;
  logic [15:0] lockCnt_q;
  logic        lockFilt_q;
  logic        lockPin_q;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      lockMeta_q <= 1'b0;
      lockSync_q <= 1'b0;
      lockPrev_q <= 1'b0;
    end else begin
      lockMeta_q <= lockRaw;
      lockSync_q <= lockMeta_q;
      lockPrev_q <= lockSync_q;
    end
  end

  // Filter: level must hold LOCK_FILT cycles before it is passed on
  always_ff @(posedge core_clk) begin
    if (rst) begin
      lockCnt_q  <= 16'h0000;
      lockFilt_q <= 1'b0;
    end else if (lockSync_q != lockPrev_q) begin
      lockCnt_q <= 16'h0000;
    end else if (lockCnt_q == 16'(LOCK_FILT - 1)) begin
      lockFilt_q <= lockSync_q;
    end else begin
      lockCnt_q <= lockCnt_q + 16'h0001;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      lockPin_q <= 1'b0;
    end else begin
      lockPin_q <= lockEn_q & lockFilt_q;
    end
  end

  // Output wiring
  assign lockPin = lockPin_q;
  assign {divInteger, fracNumerator, fracDenominator} = {divInt_q, fracOut_q, den_q};
  assign {refDivide, refFreqCode, txMode, bandSelect} = {refDiv_q, refOut_q, tx_q, bandOut_q};
  assign {upperOscEn, lowerOscEn, outLevelSel} = {upperEn_q, lowerEn_q, levelOut_q};
  assign {builtinWordsSel, cfgOneFixed, wordLoaded} = {builtinOut_q, fixedOneOut_q, loaded_q};
  assign {cfgTwoWord, cfgThreeWord} = {twoOut_q, threeOut_q};
  assign {cfgFourWord, cfgFiveWord} = {fourOut_q, fiveOut_q};

endmodule

// ===== include/fnd_pkg.sv
// Constants and types for the fractional-N divider configuration block
package fnd_pkg;
  timeunit 1ns;
  timeprecision 100ps;

  // Serial word layout
  localparam int unsigned WORD_W = 24;
  typedef logic [WORD_W-1:0] fnd_word_t;

  // Word indices (address field values)
  localparam logic [1:0] ADDR_FREQ = 2'h0;
  localparam logic [1:0] ADDR_ONE  = 2'h1;
  localparam logic [1:0] ADDR_TWO  = 2'h2;
  localparam logic [2:0] ADDR_W3   = 3'h3;
  localparam logic [3:0] ADDR_W4   = 4'h7;
  localparam logic [4:0] ADDR_W5   = 5'h0F;

  // Frequency word fields
  localparam int unsigned FW_DIR_BIT  = 23;
  localparam int unsigned FW_BAND_BIT = 19;
  localparam int unsigned FW_MAIN_HI  = 18;
  localparam int unsigned FW_MAIN_LO  = 15;
  localparam int unsigned FW_SWAL_HI  = 14;
  localparam int unsigned FW_SWAL_LO  = 12;
  localparam int unsigned FW_FRAC_HI  = 11;
  localparam int unsigned FW_FRAC_LO  = 2;

  // First configuration word fields
  localparam int unsigned C1_BUILTIN_BIT = 23;
  localparam int unsigned C1_FIXED_HI    = 22;
  localparam int unsigned C1_FIXED_LO    = 7;
  localparam int unsigned C1_LOCK_BIT    = 6;
  localparam int unsigned C1_LEVEL_HI    = 5;
  localparam int unsigned C1_LEVEL_LO    = 4;
  localparam int unsigned C1_REF_HI      = 3;
  localparam int unsigned C1_REF_LO      = 2;

  // Built-in contents of the fixed words
  localparam logic [15:0] C1_FIXED_DEF = 16'h2502;
  localparam fnd_word_t   C2_DEF       = 24'hC87806;
  localparam fnd_word_t   W3_DEF       = 24'h86801B;
  localparam fnd_word_t   W4_DEF       = 24'h03A327;
  localparam fnd_word_t   W5_DEF       = 24'h00000F;

  // Prescaler multipliers per band
  localparam logic [7:0] MULT_UPPER = 8'h08;
  localparam logic [7:0] MULT_LOWER = 8'h04;

  // Reference divide ratio per reference code
  localparam logic [1:0] REF_DIV_ONE = 2'h1;
  localparam logic [1:0] REF_DIV_TWO = 2'h2;

  // Denominators: receive, transmit lower band, transmit upper band
  localparam logic [9:0] DEN_RX_00 = 10'h1F8;   // 504
  localparam logic [9:0] DEN_RX_01 = 10'h240;   // 576
  localparam logic [9:0] DEN_RX_10 = 10'h1F8;   // 504
  localparam logic [9:0] DEN_RX_11 = 10'h208;   // 520
  localparam logic [9:0] DEN_TL_00 = 10'h276;   // 630
  localparam logic [9:0] DEN_TL_01 = 10'h2D0;   // 720
  localparam logic [9:0] DEN_TL_10 = 10'h276;   // 630
  localparam logic [9:0] DEN_TL_11 = 10'h28A;   // 650
  localparam logic [9:0] DEN_TU_00 = 10'h237;   // 567
  localparam logic [9:0] DEN_TU_01 = 10'h288;   // 648
  localparam logic [9:0] DEN_TU_10 = 10'h237;   // 567
  localparam logic [9:0] DEN_TU_11 = 10'h249;   // 585

  // Reset values of programmed fields
  localparam logic [1:0] REF_CODE_RST  = 2'h0;
  localparam logic [1:0] LEVEL_RST     = 2'h0;
  localparam logic [3:0] MAIN_RST      = 4'h2;

  // Lock indication filter length in core clock cycles
  localparam int unsigned LOCK_FILT_CYC = 16;

endpackage

// ===== verif/fnd_config_bench.sv
// Self-checking bench for the divider configuration block
module fnd_config_bench
  import fnd_pkg::*;
();
  timeunit 1ns;
  timeprecision 100ps;

  logic       core_clk = 1'b0, rst = 1'b1, lockRaw = 1'b0;
  wire logic  serClk, serData, latchStrobe;
  logic       lockPin, txMode, bandSelect, upperOscEn, lowerOscEn, builtinWordsSel, wordLoaded;
  logic [7:0] divInteger;
  logic [9:0] fracNumerator, fracDenominator;
  logic [1:0] refDivide, refFreqCode, outLevelSel;
  logic [15:0] cfgOneFixed;
  fnd_word_t  cfgTwoWord, cfgThreeWord, cfgFourWord, cfgFiveWord;
  int         fails = 0, nChecks = 0, nLoads = 0;

  fnd_config #(.LOCK_FILT(4)) dut_u (
    .core_clk(core_clk), .rst(rst), .serClk(serClk), .serData(serData),
    .latchStrobe(latchStrobe), .lockRaw(lockRaw), .lockPin(lockPin),
    .divInteger(divInteger), .fracNumerator(fracNumerator),
    .fracDenominator(fracDenominator), .refDivide(refDivide), .refFreqCode(refFreqCode),
    .txMode(txMode), .bandSelect(bandSelect), .upperOscEn(upperOscEn),
    .lowerOscEn(lowerOscEn), .outLevelSel(outLevelSel), .builtinWordsSel(builtinWordsSel),
    .cfgOneFixed(cfgOneFixed), .cfgTwoWord(cfgTwoWord), .cfgThreeWord(cfgThreeWord),
    .cfgFourWord(cfgFourWord), .cfgFiveWord(cfgFiveWord), .wordLoaded(wordLoaded));
  fnd_host_model host_u (.serClk(serClk), .serData(serData), .latchStrobe(latchStrobe));

  initial forever #12.5 core_clk = ~core_clk;
  always @(negedge core_clk) if (wordLoaded === 1'b1) nLoads <= nLoads + 1;

  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    nChecks++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic printVerdict();
    $display("checks %0d mismatches %0d", nChecks, fails);
    if (fails == 0 && nChecks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic put(input fnd_word_t w);
    @(negedge core_clk);
    host_u.send(w);
    repeat (3) @(negedge core_clk);
  endtask

  function automatic fnd_word_t cfgOne(logic bi, logic ld, logic [1:0] lv, logic [1:0] rc,
                                       logic [15:0] fx);
    return {bi, fx, ld, lv, rc, 2'h1};
  endfunction

  function automatic fnd_word_t freqWord(logic tx, logic bs, logic [3:0] m, logic [2:0] a,
                                         logic [9:0] f);
    return {tx, 3'h0, bs, m, a, f, 2'h0};
  endfunction

  function automatic logic [9:0] expDen(logic tx, logic bs, logic [1:0] rc);
    if (!tx) return rc == 2'h1 ? 10'h240 : rc == 2'h3 ? 10'h208 : 10'h1F8;
    if (!bs) return rc == 2'h1 ? 10'h2D0 : rc == 2'h3 ? 10'h28A : 10'h276;
    return rc == 2'h1 ? 10'h288 : rc == 2'h3 ? 10'h249 : 10'h237;
  endfunction

  function automatic logic [7:0] expDiv(logic bs, logic [3:0] m, logic [2:0] a);
    return (bs ? 8'h08 : 8'h04) * {4'h0, m} + {5'h00, a};
  endfunction

  initial begin
    #200us;
    fails++;
    printVerdict();
  end

  initial begin
    logic [3:0] m;
    logic [2:0] a, amax;
    logic [9:0] f, d;
    logic [1:0] lv;
    fnd_word_t  w, v2;
    fnd_word_t  v [3];
    int         base;
    base = $urandom(32'h05E7);
    repeat (20) @(posedge core_clk);
    @(negedge core_clk) rst = 1'b0;
    repeat (2) @(negedge core_clk);
    check(fracDenominator, 24'h1F8);
    check(lowerOscEn, 24'h1);
    check(cfgTwoWord, C2_DEF);
    check(lockPin, 24'h0);
    // word two first, word zero last
    put(C2_DEF);
    for (int i = 0; i < 16; i++) begin
      lv = 2'($urandom);
      m = 4'(2 + $urandom_range(13));
      amax = i[2] ? 3'h7 : 3'h3;
      a = 3'($urandom_range((m - 1) < amax ? m - 1 : amax));
      d = expDen(i[3], i[2], i[1:0]);
      f = 10'($urandom_range(d - 1));
      if (i == 15) begin
        m = 4'hF;
        f = d - 10'h001;
      end
      base = nLoads;
      put(cfgOne(1'b1, 1'b1, lv, i[1:0], C1_FIXED_DEF));
      put(freqWord(i[3], i[2], m, a, f));
      check(24'(nLoads - base), 24'h2);
      check(refFreqCode, i[1:0]);
      check(outLevelSel, lv);
      check(refDivide, i[1] ? 24'h2 : 24'h1);
      check(fracDenominator, d);
      check(divInteger, expDiv(i[2], m, a));
      check(fracNumerator, f);
      check({txMode, bandSelect, upperOscEn, lowerOscEn}, {i[3], i[2], i[2], ~i[2]});
      check(builtinWordsSel, 24'h1);
    end
    w = $urandom;
    put(cfgOne(1'b0, 1'b1, 2'h0, 2'h0, w[15:0]));
    check(cfgOneFixed, w[15:0]);
    check(builtinWordsSel, 24'h0);
    v2 = {w[23:2], 2'h2};
    put(v2);
    check(cfgTwoWord, v2);
    for (int k = 0; k < 3; k++) begin
      v[k] = (w & ~((24'h8 << k) - 24'h1)) | ((24'h4 << k) - 24'h1);
      put(v[k]);
    end
    check(cfgThreeWord, v[0]);
    check(cfgFourWord, v[1]);
    check(cfgFiveWord, v[2]);
    // Unmapped address changes nothing
    base = nLoads;
    put({~w[23:5], 5'h1F});
    check(24'(nLoads - base), 24'h0);
    put(cfgOne(1'b1, 1'b1, 2'h0, 2'h0, ~C1_FIXED_DEF));
    check(builtinWordsSel, 24'h1);
    check(cfgOneFixed, C1_FIXED_DEF);
    check(cfgTwoWord, C2_DEF);
    check(cfgThreeWord, W3_DEF);
    put({~w[23:3], 3'h3});
    put(cfgOne(1'b0, 1'b1, 2'h0, 2'h0, w[15:0]));
    check(cfgThreeWord, v[0]);
    check(cfgTwoWord, v2);
    @(negedge core_clk) lockRaw = 1'b1;
    repeat (3) @(negedge core_clk);
    check(lockPin, 24'h0);
    repeat (9) @(negedge core_clk);
    check(lockPin, 24'h1);
    lockRaw = 1'b0;
    repeat (2) @(negedge core_clk);
    lockRaw = 1'b1;
    repeat (12) @(negedge core_clk);
    check(lockPin, 24'h1);
    put(cfgOne(1'b1, 1'b0, 2'h0, 2'h0, C1_FIXED_DEF));
    check(lockPin, 24'h0);
    printVerdict();
  end
endmodule

// ===== verif/fnd_config_monitor.sv
// Concurrent checks on the divider configuration block ports
module fnd_config_monitor
  import fnd_pkg::*;
#(
  parameter int unsigned LOCK_FILT = fnd_pkg::LOCK_FILT_CYC
) (
  // Clock and reset
  input wire logic          core_clk,
  input wire logic          rst,
  // Link and lock
  input wire logic          latchStrobe,
  input wire logic          lockRaw,
  input wire logic          lockPin,
  // Divide setting and mode
  input wire logic [9:0]    fracDenominator,
  input wire logic [1:0]    refDivide,
  input wire logic [1:0]    refFreqCode,
  input wire logic          txMode,
  input wire logic          bandSelect,
  input wire logic          upperOscEn,
  input wire logic          lowerOscEn,
  // Effective words
  input wire logic          builtinWordsSel,
  input wire logic [15:0]   cfgOneFixed,
  input fnd_pkg::fnd_word_t cfgTwoWord,
  input fnd_pkg::fnd_word_t cfgThreeWord,
  input wire logic          wordLoaded
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);

  function automatic logic [9:0] denOf(logic tx, logic bs, logic [1:0] rc);
    if (!tx) return rc == 2'h1 ? DEN_RX_01 : rc == 2'h3 ? DEN_RX_11 : DEN_RX_00;
    if (!bs) return rc == 2'h1 ? DEN_TL_01 : rc == 2'h3 ? DEN_TL_11 : DEN_TL_00;
    return rc == 2'h1 ? DEN_TU_01 : rc == 2'h3 ? DEN_TU_11 : DEN_TU_00;
  endfunction

  sequence loadTail;
    wordLoaded ##1 !wordLoaded [*2];
  endsequence
  sequence modeSteady;
    $stable(txMode) && $stable(bandSelect) && $stable(refFreqCode);
  endsequence

  osc_one_hot_a: assert property (upperOscEn == bandSelect && lowerOscEn != bandSelect)
    else $error("oscillator enables disagree with band");
  ref_divide_a: assert property ($stable(refFreqCode) |->
    refDivide == (refFreqCode[1] ? 2'h2 : 2'h1)) else $error("reference divide wrong");
  denom_table_a: assert property (modeSteady |->
    fracDenominator == denOf(txMode, bandSelect, refFreqCode)) else $error("denominator wrong");
  lock_filter_a: assert property ($rose(lockPin) |->
    $past(lockRaw, 3) && $past(lockRaw, LOCK_FILT)) else $error("lock rose unfiltered");
  load_pulse_a: assert property ($rose(wordLoaded) |-> loadTail)
    else $error("load pulse not single");
  load_cause_a: assert property (wordLoaded |-> $past(latchStrobe, 3))
    else $error("load without strobe");
  den_recompute_a: assert property ($changed(fracDenominator) |->
    wordLoaded || $past(wordLoaded) || $past(wordLoaded, 2)) else $error("denominator moved");
  builtin_words_a: assert property (builtinWordsSel && $past(builtinWordsSel) |->
    cfgTwoWord == C2_DEF && cfgThreeWord == W3_DEF && cfgOneFixed == C1_FIXED_DEF)
    else $error("built-in words not shown");
endmodule

bind fnd_config fnd_config_monitor #(.LOCK_FILT(LOCK_FILT)) mon_u (
  .core_clk(core_clk), .rst(rst), .latchStrobe(latchStrobe), .lockRaw(lockRaw),
  .lockPin(lockPin), .fracDenominator(fracDenominator), .refDivide(refDivide),
  .refFreqCode(refFreqCode), .txMode(txMode), .bandSelect(bandSelect),
  .upperOscEn(upperOscEn), .lowerOscEn(lowerOscEn), .builtinWordsSel(builtinWordsSel),
  .cfgOneFixed(cfgOneFixed), .cfgTwoWord(cfgTwoWord), .cfgThreeWord(cfgThreeWord),
  .wordLoaded(wordLoaded));

// ===== verif/fnd_host_model.sv
// Host model driving the three-wire programming link
module fnd_host_model
  import fnd_pkg::*;
(
  // Serial programming link
  output logic serClk,
  output logic serData,
  output logic latchStrobe
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    serClk = 1'b0;
    serData = 1'b0;
    latchStrobe = 1'b0;
  end

  task automatic send(input fnd_word_t w);
    for (int i = WORD_W - 1; i >= 0; i--) begin
      serData = w[i];
      #7.5 serClk = 1'b1;
      #7.5 serClk = 1'b0;
    end
    // Released data line shows the inverse
    serData = ~w[0];
    #30 latchStrobe = 1'b1;
    #300 latchStrobe = 1'b0;
    #150;
  endtask
endmodule
